/* hdl/serial_port_pkg.sv */
// Package with the constants and types of the serial control port.
// Overview of operation
// - The serial output changes on each falling serial clock edge, giving the next shift register bit.
// - While chip select is high the serial output is released to high impedance.
// - While chip select is low the input line is sampled into the input shift register on each rising clock edge.
// - While chip select is high no input bit is shifted in, whatever the serial clock does.
// - The serial clock may run continuously or with gaps while selected and bits still move correctly.
// - The active-low interrupt output goes low on PLL ready, comparator trip or alarm.
// - The active-low result-ready output goes low when a new result arrives and high after a full word is read.
package serial_port_pkg;

    localparam int WORD_BITS = 16;
    localparam int CNT_BITS  = 5;
    localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
    localparam int BUF_DEPTH = 2;

    typedef logic [WORD_BITS-1:0] word_t;

endpackage

/* hdl/word_stream_if.sv */
// Interface carrying a valid-ready word stream between modules.
`timescale 1ns/10ps
interface word_stream_if;
    import serial_port_pkg::*;
    logic  valid;
    logic  ready;
    word_t data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

/* hdl/word_buffer.sv */
// Two-entry valid-ready buffer for serial words.
`timescale 1ns/10ps
module word_buffer
    import serial_port_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   reset_n,
    word_stream_if.sink   in_port,
    word_stream_if.source out_port
);
    word_t    mem_q [BUF_DEPTH];
    logic     wr_ptr_q;
    logic     rd_ptr_q;
    logic [1:0] count_q;
    logic     push;
    logic     pop;

    // Full and empty come straight from the occupancy count.
    assign in_port.ready  = (count_q != 2'(BUF_DEPTH));
    assign out_port.valid = (count_q != 2'h0);
    assign out_port.data  = mem_q[rd_ptr_q];
    assign push = in_port.valid && in_port.ready;
    assign pop  = out_port.valid && out_port.ready;

    // Storage writes on accepted words.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_port.data;
        end
    end

    // Pointers and count track pushes and pops.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + 2'(push) - 2'(pop);
        end
    end
endmodule // word_buffer

/* hdl/serial_control_port.sv */
// Serial control port with interrupt and result-ready outputs.
`timescale 1ns/10ps
module serial_control_port
    import serial_port_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  din,
    output logic                       dout,
    output logic                       dout_oe,
    output logic                       int_n,
    output logic                       result_ready_n,
    input  wire logic                  pll_ready,
    input  wire logic                  comp_trip,
    input  wire logic                  alarm,
    input  wire serial_port_pkg::word_t tx_word,
    input  wire logic                  tx_new,
    output serial_port_pkg::word_t     rx_data,
    output logic                       rx_valid,
    input  wire logic                  rx_ready
);
    import serial_port_pkg::*;

    logic [1:0]        sclk_sync_q;
    logic [1:0]        cs_sync_q;
    logic [1:0]        din_sync_q;
    logic              sclk_prev_q;
    logic              rise;
    logic              fall;
    logic              selected;
    word_t             rx_shift_q;
    word_t             tx_shift_q;
    word_t             tx_hold_q;
    logic [CNT_BITS-1:0] rx_cnt_q;
    logic [CNT_BITS-1:0] tx_cnt_q;
    logic              word_done;
    logic              ready_n_q;
    word_stream_if     to_buf ();
    word_stream_if     from_buf ();

    // Two-stage synchronisers for all pins from the host.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sclk_sync_q <= 2'h0;
            cs_sync_q   <= 2'h3;
            din_sync_q  <= 2'h0;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[0], sclk};
            cs_sync_q   <= {cs_sync_q[0], cs_n};
            din_sync_q  <= {din_sync_q[0], din};
            sclk_prev_q <= sclk_sync_q[1];
        end
    end

    // Edges are found only on host-made clock edges, so gaps are harmless.
    assign selected = !cs_sync_q[1];
    assign rise = selected && sclk_sync_q[1] && !sclk_prev_q;
    assign fall = selected && !sclk_sync_q[1] && sclk_prev_q;
    assign word_done = rise && (rx_cnt_q == CNT_BITS'(WORD_BITS - 1));

    // Input shifter samples on rising edges while selected only.
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !selected) begin
            rx_shift_q <= WORD_RESET;
            rx_cnt_q   <= CNT_RESET;
        end else if (rise) begin
            rx_shift_q <= {rx_shift_q[WORD_BITS-2:0], din_sync_q[1]};
            rx_cnt_q   <= word_done ? CNT_RESET : rx_cnt_q + 1'b1;
        end
    end

    // Completed words enter the buffer; a word completed while it is full is dropped.
    assign to_buf.valid = word_done;
    assign to_buf.data  = {rx_shift_q[WORD_BITS-2:0], din_sync_q[1]};

    word_buffer u_buf (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .in_port  (to_buf),
        .out_port (from_buf)
    );

    assign rx_data  = from_buf.data;
    assign rx_valid = from_buf.valid;
    assign from_buf.ready = rx_ready;

    // Latest result word waits here until a frame starts.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tx_hold_q <= WORD_RESET;
        end else if (tx_new) begin
            tx_hold_q <= tx_word;
        end
    end

    // Output shifter moves to the next bit on each falling edge, MSB first.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tx_shift_q <= WORD_RESET;
            tx_cnt_q   <= CNT_RESET;
        end else if (!selected) begin
            tx_shift_q <= tx_hold_q;
            tx_cnt_q   <= CNT_RESET;
        end else if (fall) begin
            if (tx_cnt_q == CNT_BITS'(WORD_BITS - 1)) begin
                tx_shift_q <= tx_hold_q;
                tx_cnt_q   <= CNT_RESET;
            end else begin
                tx_shift_q <= {tx_shift_q[WORD_BITS-2:0], 1'b0};
                tx_cnt_q   <= tx_cnt_q + 1'b1;
            end
        end
    end

    // Output pin drive and release.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            dout    <= tx_shift_q[WORD_BITS-1];
            dout_oe <= selected;
        end
    end

    // Result-ready falls on a new result; a finished word read clears it, set wins.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ready_n_q <= 1'b1;
        end else if (tx_new) begin
            ready_n_q <= 1'b0;
        end else if (word_done) begin
            ready_n_q <= 1'b1;
        end
    end
    assign result_ready_n = ready_n_q;

    // Interrupt is low while any event source is active.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            int_n <= 1'b1;
        end else begin
            int_n <= !(pll_ready || comp_trip || alarm);
        end
    end
endmodule // serial_control_port

/* verification/scp_asserts.sv */
// Checker of the serial control port outputs.
`timescale 1ns/10ps
module scp_chk
    import serial_port_pkg::*;
(
    input wire logic sys_clk, reset_n, cs_n, tx_new, rx_ready, pll_ready,
    input wire logic comp_trip, alarm, dout_oe, int_n, result_ready_n, rx_valid,
    input wire serial_port_pkg::word_t rx_data
);
    // Five cycles of steady select outlast the synchroniser.
    sequence cs_idle;
        cs_n [*5];
    endsequence
    sequence cs_sel;
        !cs_n [*5];
    endsequence
    wire ev = pll_ready | comp_trip | alarm;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_RST: assert property (disable iff (1'b0) !reset_n |=> int_n && result_ready_n
        && !dout_oe && !rx_valid) else $error("bad reset value");
    AST_OE_OFF: assert property (cs_idle |-> !dout_oe) else $error("dout driven");
    AST_OE_ON: assert property (cs_sel |-> dout_oe) else $error("dout released");
    AST_INT_LO: assert property (!int_n |-> $past(ev)) else $error("stray int");
    AST_INT_HI: assert property (ev |=> !int_n) else $error("missed int");
    AST_RRN_SET: assert property (tx_new |=> !result_ready_n) else $error("no ready");
    AST_RRN_FELL: assert property ($fell(result_ready_n) |-> $past(tx_new))
        else $error("rrn");
    AST_RRN_ROSE: assert property ($rose(result_ready_n) && $past(reset_n) |-> rx_valid)
        else $error("rrn cleared without word");
    AST_RXV_HOLD: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("word lost");
endmodule // scp_chk
bind serial_control_port scp_chk chk_u (.sys_clk, .reset_n, .cs_n, .tx_new, .rx_ready,
    .pll_ready, .comp_trip, .alarm, .dout_oe, .int_n, .result_ready_n, .rx_valid, .rx_data);

/* verification/host_model.sv */
// Host model that masters the serial link.
`timescale 1ns/10ps
module host_model
    import serial_port_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic miso,
    output logic      sclk, cs_n, din
);
    initial {sclk, cs_n, din} = 3'h2;
    // Sends nb bits MSB first with select level cs and collects the reply.
    task automatic xfer(input word_t w, input int nb, gap, input logic cs, output word_t r);
        r = '0;
        cs_n <= cs;
        for (int i = WORD_BITS - 1; i >= WORD_BITS - nb; i--) begin
            din <= w[i];
            repeat (4 + gap) @(posedge sys_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            r[i] = miso;
            sclk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule // host_model

/* verification/tb_top.sv */
// Self-checking bench of the serial control port.
`timescale 1ns/10ps
module tb_top;
    import serial_port_pkg::*;
    typedef struct { word_t tx; word_t hw; int gap; } row_t;
    row_t rows [3] = '{'{16'h8001, 16'h1234, 0}, '{16'h7ffe, 16'hffff, 5}, '{16'ha5c3, 16'h0000, 1}};
    logic sys_clk = 0, reset_n = 0, pll_ready = 0, comp_trip = 0, alarm = 0, tx_new = 0;
    logic rx_ready = 0, line_q = 0, sclk, cs_n, din, dout, dout_oe, int_n, result_ready_n, rx_valid;
    word_t tx_word = '0, rx_data, r;
    int n_fail = 0, checks_done = 0, cyc = 0;
    // A released line shows the inverse of its last driven level.
    wire miso = dout_oe ? dout : ~line_q;
    serial_control_port dut_u (.sys_clk, .reset_n, .sclk, .cs_n, .din, .dout, .dout_oe, .int_n,
        .result_ready_n, .pll_ready, .comp_trip, .alarm, .tx_word, .tx_new, .rx_data, .rx_valid,
        .rx_ready);
    host_model host_u (.sys_clk, .miso, .sclk, .cs_n, .din);
    initial forever #10 sys_clk = ~sys_clk;
    // Tracks the line and cuts a hung run short.
    always @(posedge sys_clk) begin
        if (dout_oe) line_q <= dout;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk(input string s, input word_t e, g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Reset, table of words, then events, deselect, partial word and buffer.
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1;
        chk("oe", 0, dout_oe);
        repeat (4) @(posedge sys_clk);
        foreach (rows[i]) begin
            tx_word <= rows[i].tx;
            tx_new <= 1;
            @(posedge sys_clk) tx_new <= 0;
            #1 chk("rrn", 0, result_ready_n);
            host_u.xfer(rows[i].hw, 16, rows[i].gap, 0, r);
            chk("tx", rows[i].tx, r);
            chk("rx", rows[i].hw, rx_data);
            chk("rrn", 1, result_ready_n);
            rx_ready <= 1;
            @(posedge sys_clk) rx_ready <= 0;
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) {alarm, comp_trip, pll_ready} <= 3'h1 << i;
            repeat (2) @(posedge sys_clk);
            #1 chk("int_n", i == 3, int_n);
        end
        host_u.xfer(16'hffff, 16, 0, 1, r);
        host_u.xfer(16'hffff, 5, 0, 0, r);
        chk("rxv", 0, rx_valid);
        for (int i = 0; i < 3; i++) host_u.xfer(16'h0f00 + i, 16, 0, 0, r);
        for (int i = 0; i < 2; i++) begin
            chk("buf", 16'h0f00 + i, rx_data);
            rx_ready <= 1;
            @(posedge sys_clk) rx_ready <= 0;
            @(posedge sys_clk);
        end
        chk("empty", 0, rx_valid);
        final_report();
    end
endmodule // tb_top
